// ===== rtl/mag_switch_map.svh
/*
 File: timing, threshold and reset constants for the duty-cycled magnetic switch.
 Assumes: included by bare name; constants only.
*/
`ifndef MAG_SWITCH_MAP_SVH
`define MAG_SWITCH_MAP_SVH
// clock rate in kHz
`define MS_CLK_KHZ 100000
// awake time in microseconds, typical
`define MS_AWAKE_US 50
// sampling period in milliseconds, typical
`define MS_PERIOD_MS 50
// awake phase length in cycles, typical time rounds down
`define MS_AWAKE_CYC ((`MS_AWAKE_US * `MS_CLK_KHZ) / 1000)
// sampling period in cycles
`define MS_PERIOD_CYC (`MS_PERIOD_MS * `MS_CLK_KHZ)
// field thresholds in gauss
`define MS_OP_GAUSS 33
`define MS_RP_GAUSS 23
`define MS_HYST_GAUSS 10
// complete awake phases needed before the output counts as valid
`define MS_VALID_PHASES 2
// reset value of the output pin: high means off
`define MS_OUT_RESET 1'b1
`endif

// ===== rtl/mag_switch_pkg.sv
/*
 File: types shared by the duty-cycled magnetic switch.
 Assumes: nothing beyond the constants header.
*/
`default_nettype none
package mag_switch_pkg;
	typedef enum logic {MODE_OMNI, MODE_UNI} mode_e;
	typedef logic signed [7:0] field_t;
endpackage : mag_switch_pkg
`default_nettype wire

// ===== rtl/mag_duty_timer.sv
/*
 File: hibernating timer that splits each period into an awake and a sleep phase.
 Assumes: one clock, synchronous active-high reset.
*/
`include "mag_switch_map.svh"
`default_nettype none
module mag_duty_timer #(
	parameter int PERIOD_CYC = `MS_PERIOD_CYC,
	parameter int AWAKE_CYC = `MS_AWAKE_CYC
) (
	// clock and reset
	input wire logic ref_clk,
	input wire logic sys_rst,
	// phase outputs
	output logic awake,
	output logic awakeEnd
);
	logic [31:0] count;
	logic [31:0] next_count;
	// period counter, awake during the first AWAKE_CYC cycles
	always_comb
	begin
		if (count == 32'(PERIOD_CYC - 1))
			next_count = 32'h0;
		else
			next_count = count + 32'h1;
	end
	always_ff @(posedge ref_clk)
	begin
		if (sys_rst)
			count <= 32'h0;
		else
			count <= next_count;
	end
	assign awake = (count < 32'(AWAKE_CYC));
	assign awakeEnd = (count == 32'(AWAKE_CYC - 1));
endmodule : mag_duty_timer
`default_nettype wire

// ===== rtl/mag_switch.sv
/*
 File: decision logic of a duty-cycled magnetic switch with selectable pole mode.
 Assumes: field sample arrives as a signed gauss value, synchronous to ref_clk;
 the analog pull-up on the select pin is steered by selPullEn.
*/
`include "mag_switch_map.svh"
`default_nettype none
module mag_switch
	import mag_switch_pkg::*;
#(
	parameter int PERIOD_CYC = `MS_PERIOD_CYC,
	parameter int AWAKE_CYC = `MS_AWAKE_CYC,
	parameter int OP_GAUSS = `MS_OP_GAUSS,
	parameter int RP_GAUSS = `MS_RP_GAUSS
) (
	// clock and reset
	input wire logic ref_clk,
	input wire logic sys_rst,
	// sensor and select
	input wire mag_switch_pkg::field_t field,
	input wire logic selIn,
	output logic selPullEn,
	// switch output pin, push-pull
	output logic switchOutN,
	output logic switchOutOeN,
	// state
	output logic outValid
);
	import mag_switch_pkg::*;

	localparam field_t OP_T = field_t'(OP_GAUSS);
	localparam field_t RP_T = field_t'(RP_GAUSS);
	localparam logic [1:0] VALID_N = 2'(`MS_VALID_PHASES);
	// phase count for a phase cut by a select change; wraps to zero at its sample
	localparam logic [1:0] SPOILT = 2'h3;

	logic awake;
	logic awakeEnd;
	logic detect;
	logic next_detect;
	logic [1:0] phases;
	logic [1:0] next_phases;
	mode_e mode;
	mode_e next_mode;
	mode_e selMode;
	logic awakePrev;
	logic next_awakePrev;
	logic awakeFirst;
	logic [31:0] awakeLen;
	logic [31:0] next_awakeLen;

	// phase timer
	mag_duty_timer #(
		.PERIOD_CYC(PERIOD_CYC),
		.AWAKE_CYC(AWAKE_CYC)
	) u_timer (
		.ref_clk(ref_clk),
		.sys_rst(sys_rst),
		.awake(awake),
		.awakeEnd(awakeEnd)
	);

	// decision for one sample with hysteresis
	function automatic logic decide(input mode_e m, input field_t b, input logic on);
		logic south;
		logic north;
		south = on ? (b >= RP_T) : (b > OP_T);
		north = on ? (b <= -RP_T) : (b < -OP_T);
		if (m == MODE_UNI)
			decide = south;
		else
			decide = south | north;
	endfunction : decide

	// pull-up only while awake; floating pin reads high then
	assign selPullEn = awake;
	assign selMode = selIn ? MODE_UNI : MODE_OMNI;
	// first cycle of an awake phase; a select change seen here came in during sleep
	assign awakeFirst = awake && !awakePrev;

	// sample at end of awake phase, count completed phases since power-up or mode change
	always_comb
	begin
		next_detect = detect;
		next_phases = phases;
		next_mode = mode;
		next_awakePrev = awake;
		if (awakeEnd)
		begin
			next_detect = decide(selMode, field, detect);
			next_mode = selMode;
			if (selMode != mode)
				next_phases = awakeFirst ? 2'h1 : 2'h0; // only a whole phase counts
			else if (phases != VALID_N)
				next_phases = phases + 2'h1; // SPOILT wraps to zero here
		end
		else if (awake && selMode != mode)
		begin
			next_mode = selMode;
			// a change seen after the first awake cycle cuts this phase: it must not count
			next_phases = awakeFirst ? 2'h0 : SPOILT;
		end
	end
	always_ff @(posedge ref_clk)
	begin
		if (sys_rst)
		begin
			detect <= 1'b0;
			phases <= 2'h0;
			mode <= MODE_UNI;
			awakePrev <= 1'b1; // timer rests at the start of an awake phase in reset
		end
		else
		begin
			detect <= next_detect;
			phases <= next_phases;
			mode <= next_mode;
			awakePrev <= next_awakePrev;
		end
	end

	// output stays off until valid, low when detected
	assign outValid = (phases == VALID_N);
	logic next_out;
	logic outReg;
	always_comb
	begin
		next_out = outValid ? ~detect : `MS_OUT_RESET;
	end
	always_ff @(posedge ref_clk)
	begin
		if (sys_rst)
			outReg <= `MS_OUT_RESET;
		else
			outReg <= next_out;
	end
	assign switchOutN = outReg;
	assign switchOutOeN = 1'b0; // always driven

	// while valid, output only moves two cycles after a sample: decision first, then the pin
	property p_hold;
		@(posedge ref_clk) disable iff (sys_rst)
		(!$past(awakeEnd, 2) && $past(outValid) && outValid) |-> $stable(outReg);
	endproperty
	a_hold: assert property (p_hold) else $error("output moved between samples");
	// length of the current pull-up window, read only by the checks
	always_comb
	begin
		next_awakeLen = selPullEn ? awakeLen + 32'h1 : 32'h0;
	end
	always_ff @(posedge ref_clk)
	begin
		if (sys_rst)
			awakeLen <= 32'h0;
		else
			awakeLen <= next_awakeLen;
	end
	// pull-up never stays on longer than one awake phase
	property p_pull;
		@(posedge ref_clk) disable iff (sys_rst)
		selPullEn |-> (awakeLen < 32'(AWAKE_CYC));
	endproperty
	a_pull: assert property (p_pull) else $error("pull-up held past the awake phase");
	// pull-up is dropped right after the sampling cycle
	property p_pullend;
		@(posedge ref_clk) disable iff (sys_rst)
		$fell(selPullEn) |-> $past(awakeEnd);
	endproperty
	a_pullend: assert property (p_pullend) else $error("pull-up dropped off the sample");
	property p_offinvalid;
		@(posedge ref_clk) disable iff (sys_rst) !$past(outValid) |-> outReg;
	endproperty
	a_offinvalid: assert property (p_offinvalid) else $error("output on before valid");
	property p_uninorth;
		@(posedge ref_clk) disable iff (sys_rst)
		(awakeEnd && selIn && field < 0) |=> !detect;
	endproperty
	a_uninorth: assert property (p_uninorth) else $error("north field switched unipolar");
	property p_omnion;
		@(posedge ref_clk) disable iff (sys_rst)
		(awakeEnd && !selIn && field < -OP_T) |=> detect;
	endproperty
	a_omnion: assert property (p_omnion) else $error("north field missed in omnipolar");
	property p_hyst;
		@(posedge ref_clk) disable iff (sys_rst)
		(awakeEnd && detect && field >= RP_T) |=> detect;
	endproperty
	a_hyst: assert property (p_hyst) else $error("released inside hysteresis");
	property p_change;
		@(posedge ref_clk) disable iff (sys_rst)
		(awake && selMode != mode) |=> !outValid;
	endproperty
	a_change: assert property (p_change) else $error("valid right after select change");
	property p_drive;
		@(posedge ref_clk) disable iff (sys_rst)
		outValid |=> (outReg == ~$past(detect)) && !switchOutOeN;
	endproperty
	a_drive: assert property (p_drive) else $error("output level wrong");
	// a sample taken while the switch is on
	sequence s_sampleOn;
		awakeEnd && detect;
	endsequence
	// unipolar: anything below the south release point turns the switch off
	property p_unirel;
		@(posedge ref_clk) disable iff (sys_rst)
		(s_sampleOn ##0 (selIn && field < RP_T)) |=> !detect;
	endproperty
	a_unirel: assert property (p_unirel) else $error("unipolar switch not released");
	// omnipolar: inside both release points turns the switch off
	property p_omnirel;
		@(posedge ref_clk) disable iff (sys_rst)
		(s_sampleOn ##0 (!selIn && field < RP_T && field > -RP_T)) |=> !detect;
	endproperty
	a_omnirel: assert property (p_omnirel) else $error("omnipolar switch not released");
	// unipolar: a south field beyond the operate point turns the switch on
	property p_union;
		@(posedge ref_clk) disable iff (sys_rst)
		(awakeEnd && selIn && field > OP_T) |=> detect;
	endproperty
	a_union: assert property (p_union) else $error("south field missed in unipolar");
	// the decision only moves at a sample
	property p_sleephold;
		@(posedge ref_clk) disable iff (sys_rst)
		!awakeEnd |=> $stable(detect);
	endproperty
	a_sleephold: assert property (p_sleephold) else $error("decision moved between samples");
	// validity only arrives with a sample
	property p_rise;
		@(posedge ref_clk) disable iff (sys_rst)
		$rose(outValid) |-> $past(awakeEnd);
	endproperty
	a_rise: assert property (p_rise) else $error("output valid without a sample");
endmodule : mag_switch
`default_nettype wire

// ===== verification/mag_select_drv.sv
/*
 select line partner: drives the mode select or leaves it floating
 assumes selPullEn is high only while the switch is awake
*/
`default_nettype none
module mag_select_drv (
	// clock and pull-up
	input wire logic ref_clk,
	input wire logic selPullEn,
	// controller side
	input wire logic drive,
	input wire logic level,
	// select line
	output logic selIn
);
	timeunit 1ns;
	timeprecision 1ps;
	logic last;
	// a floating line with no pull-up wanders
	always_ff @(posedge ref_clk) last <= selIn;
	// driven level, else pull-up while awake
	assign selIn = drive ? level : (selPullEn | ~last);
endmodule : mag_select_drv
`default_nettype wire

// ===== verification/duty_cycled_magnetic_switch_tb.sv
/*
 self-checking bench for the magnetic switch decision logic
 assumes short timer parameters: period 20, awake 4 cycles
*/
`default_nettype none
module duty_cycled_magnetic_switch_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import mag_switch_pkg::*;
	localparam int PER = 20;
	localparam int AW = 4;
	localparam int OP = 33;
	localparam int RP = 23;
	logic ref_clk = 0;
	logic sys_rst = 1;
	logic drive = 1;
	logic level = 1;
	logic on = 0;
	field_t field = 8'h00;
	logic selIn, selPullEn, switchOutN, switchOutOeN, outValid;
	int failures = 0;
	int checked = 0;
	int cyc = 0;
	int w;
	int seed = 32'h6365;
	field_t corner [8] = '{8'h16, 8'h22, 8'h17, 8'h16, 8'h21, 8'hDE, 8'hE9, 8'hEA};
	mag_switch #(.PERIOD_CYC(PER), .AWAKE_CYC(AW), .OP_GAUSS(OP), .RP_GAUSS(RP)) dut_u (
		.ref_clk(ref_clk), .sys_rst(sys_rst), .field(field), .selIn(selIn),
		.selPullEn(selPullEn), .switchOutN(switchOutN), .switchOutOeN(switchOutOeN),
		.outValid(outValid));
	mag_select_drv sel_u (.ref_clk(ref_clk), .selPullEn(selPullEn), .drive(drive),
		.level(level), .selIn(selIn));
	always #5 ref_clk = ~ref_clk;
	// watchdog on total run length
	always @(posedge ref_clk)
	begin
		cyc++;
		if (cyc > 5000)
		begin
			failures++;
			end_of_test();
		end
	end
	task end_of_test;
		$display("checks %0d mismatches %0d", checked, failures);
		if (failures == 0 && checked > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : end_of_test
	task check(string name, logic [31:0] seen, logic [31:0] exp);
		checked++;
		if (seen !== exp)
		begin
			failures++;
			$display("BAD %s exp %0h seen %0h", name, exp, seen);
		end
	endtask : check
	task tick;
		@(posedge ref_clk);
		#1;
	endtask : tick
	// run through one awake phase, counting its length
	task sample;
		w = 0;
		while (selPullEn !== 1'b1) tick();
		while (selPullEn === 1'b1)
		begin
			tick();
			w++;
		end
		tick();
	endtask : sample
	// expected switch state after one sample
	function logic model(logic o, field_t f, logic uni);
		if (o)
			return f >= RP || (!uni && f <= -RP);
		return f > OP || (!uni && f < -OP);
	endfunction : model
	task step(field_t f, logic uni);
		field = f;
		sample();
		on = model(on, f, uni);
		check("out", switchOutN, !on);
		check("valid", outValid, 1'b1);
		check("awake", w, AW);
	endtask : step
	task run(logic uni);
		for (int i = 0; i < 8; i++) step(corner[i], uni);
		repeat (30) step(field_t'($random(seed) % 64), uni);
	endtask : run
	// change mode in sleep, output invalid until second phase
	task modeSet(logic lv);
		step(8'h00, !lv);
		drive = 1;
		level = lv;
		sample();
		check("valid", outValid, 1'b0);
		check("out", switchOutN, 1'b1);
		step(8'h00, lv);
	endtask : modeSet
	// change mode one cycle into an awake phase: that cut phase must not count
	task modeMid(logic lv);
		step(8'h00, !lv);
		while (selPullEn !== 1'b1) tick();
		tick();
		drive = 1;
		level = lv;
		sample();
		check("valid", outValid, 1'b0);
		sample();
		check("valid", outValid, 1'b0);
		check("out", switchOutN, 1'b1);
		step(8'h00, lv);
	endtask : modeMid
	initial
	begin
		repeat (8) @(posedge ref_clk);
		#1;
		sys_rst = 0;
		sample();
		check("valid", outValid, 1'b0);
		check("out", switchOutN, 1'b1);
		step(8'h00, 1'b1);
		check("oe", switchOutOeN, 1'b0);
		$display("test reset done");
		drive = 0;
		run(1'b1);
		$display("test floating unipolar done");
		modeSet(1'b0);
		run(1'b0);
		$display("test omnipolar done");
		modeSet(1'b1);
		run(1'b1);
		$display("test driven unipolar done");
		modeMid(1'b0);
		$display("test mid-awake change done");
		end_of_test();
	end
endmodule : duty_cycled_magnetic_switch_tb
`default_nettype wire
